// [design/cmp_ctl_pkg.sv]
// Purpose: Shared constants and carrier types for the comparator control.
// Assumes: 32-bit APB, one word per register, byte addresses below.
// Notes:   Every offset, field position and port or control reset value lives here.
package cmp_ctl_pkg;

   // -----------------------------------------------------------------
   // Bus geometry and register offsets
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;
   localparam logic [7:0]  OFF_CTRL    = 8'h00;
   localparam logic [7:0]  OFF_FLAG    = 8'h04;
   localparam logic [7:0]  OFF_ENABLE  = 8'h08;
   localparam logic [7:0]  OFF_INTCTL  = 8'h0C;
   localparam logic [7:0]  OFF_DIR     = 8'h10;
   localparam logic [7:0]  OFF_PORT    = 8'h14;
   localparam logic [7:0]  OFF_LATCH   = 8'h18;
   localparam logic [7:0]  OFF_ANSEL   = 8'h1C;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int unsigned BIT_CMP2_RES = 7;
   localparam int unsigned BIT_CMP1_RES = 6;
   localparam int unsigned BIT_FLAG     = 6;
   localparam int unsigned BIT_IRQ_EN   = 6;
   localparam int unsigned BIT_GIE      = 7;
   localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE     = 6;
   localparam int unsigned PIN_CMP1     = 4;
   localparam int unsigned PIN_CMP2     = 5;
   localparam int unsigned CTRL_W       = 6;

   // -----------------------------------------------------------------
   // Mode encodings and reset values
   // -----------------------------------------------------------------
   localparam logic [2:0]  MODE_OFF     = 3'h7;
   localparam logic [2:0]  MODE_MUX4    = 3'h6;
   localparam logic [2:0]  MODE_PIN_OUT = 3'h3;
   localparam logic [7:0]  RST_DIR      = 8'hFF;
   localparam logic [7:0]  RST_LATCH    = 8'h00;
   localparam logic [7:0]  RST_ANSEL    = 8'h0F;
   localparam int unsigned SYNC_STAGES  = 2;

   // Writable part of the control/status register, bits 5:0.
   typedef struct packed {
      logic       cmp2_invert;
      logic       cmp1_invert;
      logic       input_switch;
      logic [2:0] mode;
   } ctrl_t;

   localparam ctrl_t RST_CTRL = '{cmp2_invert : 1'b0, cmp1_invert : 1'b0,
                                  input_switch : 1'b0, mode : MODE_OFF};

   // Steering handed to the analog comparator macro.
   typedef struct packed {
      logic       cmp1_on;
      logic       cmp2_on;
      logic       ref_on_positive;
      logic       neg_to_ref_pins;
      logic [2:0] mode;
   } analog_ctl_t;

endpackage : cmp_ctl_pkg

// [design/cmp_sync.sv]
// Purpose: Multi-bit level synchroniser for the comparator results.
// Assumes: Each bit is an independent slow level; no word coherence.
// Notes:   The first stage feeds the next stage and nothing else.
`timescale 1ns/1ps
module cmp_sync #(
   parameter int unsigned WIDTH  = 2,
   parameter int unsigned STAGES = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage_ff [STAGES];

   // Refuse a chain too short to resolve metastability.
   if (STAGES < 2 || WIDTH < 1) begin : g_bad
      $error("cmp_sync needs at least two stages and one bit");
   end

   // Shift chain; reset to constants only.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < STAGES; i++)
            stage_ff[i] <= '0;
      end
      else
      begin
         stage_ff[0] <= d;
         for (int i = 1; i < STAGES; i++)
            stage_ff[i] <= stage_ff[i-1];
      end
   end

   assign q = stage_ff[STAGES-1];

endmodule : cmp_sync

// [design/cmp_change_detect.sv]
// Purpose: Holds the last-seen comparator results and flags a mismatch.
// Assumes: sample is already synchronous to clk.
// Notes:   capture refreshes the copy; the mismatch then ends next cycle.
`timescale 1ns/1ps
module cmp_change_detect #(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] sample,
   input  wire logic             capture,
   output logic                  mismatch
);

   logic [WIDTH-1:0] seen_ff;

   if (WIDTH < 1) begin : g_bad
      $error("cmp_change_detect needs at least one bit");
   end

   // A change landing on the capture edge misses the copy and shows as a mismatch.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         seen_ff <= '0;
      else if (capture)
         seen_ff <= sample;
   end

   // Level persists until software touches the control register.
   assign mismatch = |(sample ^ seen_ff);

endmodule : cmp_change_detect

// [design/dual_comparator_control.sv]
// Purpose: Control, status and change flag logic for two comparators.
// Assumes: APB master per AMBA rules; comparator outputs asynchronous.
// Notes:   Pins 4 and 5 may carry the raw comparator level directly.
`timescale 1ns/1ps

// Function
// - cmp2 result bit 7, inverted by cmp2_invert.
// - cmp1 result bit 6, inverted by cmp1_invert.
// - Invert bits 5 and 4, reset zero.
// - Mode 110 input switch steers negative inputs.
// - Three-bit mode field; direction register still governs.
// - Result bits read-only; writes ignored.
// - Internal reference only in mode 110, positive.
// - Pin output uses unsynchronised comparator level.
// - Direction bits enable comparator pin drive.
// - Change flag set on any output change.
// - Flag sticky; software write one sets it.
// - Request needs all three enables; flag independent.
// - Mismatch re-sets flag; control register access ends it.
// - Change during control access still shows as a mismatch.
// - Port reads return zero on analog pins.
// - Reset returns control register, mode 111.
// - Comparators run in sleep; flag wakes device when irq_en_ff is set.
module dual_comparator_control #(
   parameter int unsigned PORT_W = 8
) (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [cmp_ctl_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [cmp_ctl_pkg::DATA_W-1:0]  pwdata,
   output logic      [cmp_ctl_pkg::DATA_W-1:0]  prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic                            cmp1_raw,
   input  wire logic                            cmp2_raw,
   input  wire logic                            sleep_mode,
   input  wire logic [PORT_W-1:0]               pin_in,
   output logic      [PORT_W-1:0]               pin_out,
   output logic      [PORT_W-1:0]               pin_oe_n,
   output cmp_ctl_pkg::analog_ctl_t             analog_ctl,
   output logic                                 irq_request,
   output logic                                 wake_request
);
   import cmp_ctl_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // The comparator pins sit at fixed positions inside the port.
   if (PORT_W <= PIN_CMP2 || PORT_W > 8) begin : g_bad_port
      $error("PORT_W must cover the comparator pins and fit 8 bits");
   end

   // Address match shared by every register decode.
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        off);
      addr_is = (a == off);
   endfunction : addr_is

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   ctrl_t             ctrl_ff;
   ctrl_t             nxt_ctrl;
   logic              flag_ff;
   logic              nxt_flag;
   logic              irq_en_ff;
   logic              gie_ff;
   logic              peripheral_irq_enable_ff;
   logic [PORT_W-1:0] dir_ff;
   logic [PORT_W-1:0] latch_ff;
   logic [PORT_W-1:0] ansel_ff;
   logic [DATA_W-1:0] prdata_ff;
   logic [DATA_W-1:0] nxt_prdata;
   logic              pready_ff;
   logic              pslverr_ff;
   logic              irq_ff;
   logic              wake_ff;
   analog_ctl_t       analog_ff;
   analog_ctl_t       nxt_analog;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // One wait state: the read mux settles into prdata_ff during the
   // first access cycle, so the bus never sees a combinational path.
   wire access_start = psel & penable & ~pready_ff;
   wire access_done  = psel & penable & pready_ff;
   wire wr_done      = access_done & pwrite;
   wire sel_ctrl     = addr_is(paddr, OFF_CTRL);
   wire sel_flag     = addr_is(paddr, OFF_FLAG);
   wire sel_enable   = addr_is(paddr, OFF_ENABLE);
   wire sel_intctl   = addr_is(paddr, OFF_INTCTL);
   wire sel_dir      = addr_is(paddr, OFF_DIR);
   wire sel_port     = addr_is(paddr, OFF_PORT);
   wire sel_latch    = addr_is(paddr, OFF_LATCH);
   wire sel_ansel    = addr_is(paddr, OFF_ANSEL);
   wire mapped       = sel_ctrl | sel_flag | sel_enable | sel_intctl
                     | sel_dir | sel_port | sel_latch | sel_ansel;
   wire wr_ctrl      = wr_done & sel_ctrl;
   wire wr_flag      = wr_done & sel_flag;
   wire wr_enable    = wr_done & sel_enable;
   wire wr_intctl    = wr_done & sel_intctl;
   wire wr_dir       = wr_done & sel_dir;
   wire wr_latch     = wr_done & sel_latch;
   wire wr_ansel     = wr_done & sel_ansel;
   // Both reads and writes of the control register refresh the copy.
   wire ctrl_access  = access_done & sel_ctrl;

   // ----------------------------------------------------------------
   // Comparator result path
   // ----------------------------------------------------------------
   // A comparator that is switched off reads as low before inversion.
   wire cmp_on = (ctrl_ff.mode != MODE_OFF);
   wire live1  = (cmp1_raw & cmp_on) ^ ctrl_ff.cmp1_invert;
   wire live2  = (cmp2_raw & cmp_on) ^ ctrl_ff.cmp2_invert;

   logic [1:0] res_sync;
   logic       mismatch;

   // Results cross into pclk before anything compares them.
   cmp_sync #(
      .WIDTH  (2),
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .clk    (pclk),
      .rst_n  (presetn),
      .d      ({live2, live1}),
      .q      (res_sync)
   );

   // Copy of the last value software saw, and the mismatch against it.
   cmp_change_detect #(
      .WIDTH    (2)
   ) u_change (
      .clk      (pclk),
      .rst_n    (presetn),
      .sample   (res_sync),
      .capture  (ctrl_access),
      .mismatch (mismatch)
   );

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Only bits 5:0 are written; result bits 7:6 have no storage.
   assign nxt_ctrl = wr_ctrl ? ctrl_t'(pwdata[CTRL_W-1:0]) : ctrl_ff;

   // Sleep has no effect here, so waking leaves the contents intact.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_ff <= RST_CTRL;
      else
         ctrl_ff <= nxt_ctrl;
   end

   // ----------------------------------------------------------------
   // Change flag
   // ----------------------------------------------------------------
   // A live mismatch or a written one sets; a written zero clears.
   // Set beats clear, so a change in the clearing cycle survives.
   wire flag_set = mismatch
                 | (wr_flag & pwdata[BIT_FLAG]);
   wire flag_clr = wr_flag & ~pwdata[BIT_FLAG];
   assign nxt_flag = flag_set | (flag_ff & ~flag_clr);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_ff <= 1'b0;
      else
         flag_ff <= nxt_flag;
   end

   // ----------------------------------------------------------------
   // Interrupt enables
   // ----------------------------------------------------------------
   // Software should clear these around a mode change, since the
   // comparator output settles slowly and would raise a false flag.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_en_ff <= 1'b0;
         gie_ff    <= 1'b0;
         peripheral_irq_enable_ff   <= 1'b0;
      end
      else
      begin
         if (wr_enable)
            irq_en_ff <= pwdata[BIT_IRQ_EN];
         if (wr_intctl)
         begin
            gie_ff  <= pwdata[BIT_GIE];
            peripheral_irq_enable_ff <= pwdata[BIT_PERIPHERAL_IRQ_ENABLE];
         end
      end
   end

   // Request and wake are registered so the outputs stay glitch free.
   wire irq_next  = nxt_flag & irq_en_ff & peripheral_irq_enable_ff & gie_ff;
   wire wake_next = sleep_mode & nxt_flag & irq_en_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_ff  <= 1'b0;
         wake_ff <= 1'b0;
      end
      else
      begin
         irq_ff  <= irq_next;
         wake_ff <= wake_next;
      end
   end

   // ----------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------
   // Direction resets to input; analog select covers pins 0 to 3.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dir_ff   <= RST_DIR[PORT_W-1:0];
         latch_ff <= RST_LATCH[PORT_W-1:0];
         ansel_ff <= RST_ANSEL[PORT_W-1:0];
      end
      else
      begin
         if (wr_dir)
            dir_ff <= pwdata[PORT_W-1:0];
         if (wr_latch)
            latch_ff <= pwdata[PORT_W-1:0];
         if (wr_ansel)
            ansel_ff <= pwdata[PORT_W-1:0];
      end
   end

   // Analog pins read as zero, whatever level sits on them.
   wire [PORT_W-1:0] port_read = pin_in & ~ansel_ff;

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   // The comparator pins bypass every flop: the documented behaviour
   // is the raw comparator level, so this output path is not
   // registered and carries the comparator's own uncertainty.
   wire cmp_pins_on = (ctrl_ff.mode == MODE_PIN_OUT);

   for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      if (i == PIN_CMP1) begin : g_c1
         assign pin_out[i] = cmp_pins_on ? live1 : latch_ff[i];
      end
      else if (i == PIN_CMP2) begin : g_c2
         assign pin_out[i] = cmp_pins_on ? live2 : latch_ff[i];
      end
      else begin : g_plain
         assign pin_out[i] = latch_ff[i];
      end
   end

   // Direction bits keep control of drive even in comparator modes.
   assign pin_oe_n = dir_ff;

   // ----------------------------------------------------------------
   // Analog steering
   // ----------------------------------------------------------------
   // Reference ladder and switch matter only in the multiplexed mode.
   wire mux4 = (ctrl_ff.mode == MODE_MUX4);

   always_comb
   begin
      nxt_analog.cmp1_on         = cmp_on;
      nxt_analog.cmp2_on         = cmp_on;
      nxt_analog.ref_on_positive = mux4;
      nxt_analog.neg_to_ref_pins = mux4 & ctrl_ff.input_switch;
      nxt_analog.mode            = ctrl_ff.mode;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         analog_ff.cmp1_on         <= 1'b0;
         analog_ff.cmp2_on         <= 1'b0;
         analog_ff.ref_on_positive <= 1'b0;
         analog_ff.neg_to_ref_pins <= 1'b0;
         analog_ff.mode            <= MODE_OFF;
      end
      else
         analog_ff <= nxt_analog;
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Result bits come from the synchronised copy, so a read never
   // sees a metastable level; unused bits read as zero.
   always_comb
   begin
      nxt_prdata = '0;
      if (sel_ctrl)
      begin
         nxt_prdata[CTRL_W-1:0]  = ctrl_ff;
         nxt_prdata[BIT_CMP1_RES] = res_sync[0];
         nxt_prdata[BIT_CMP2_RES] = res_sync[1];
      end
      else if (sel_flag)
         nxt_prdata[BIT_FLAG] = flag_ff;
      else if (sel_enable)
         nxt_prdata[BIT_IRQ_EN] = irq_en_ff;
      else if (sel_intctl)
      begin
         nxt_prdata[BIT_GIE]  = gie_ff;
         nxt_prdata[BIT_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_ff;
      end
      else if (sel_dir)
         nxt_prdata[PORT_W-1:0] = dir_ff;
      else if (sel_port)
         nxt_prdata[PORT_W-1:0] = port_read;
      else if (sel_latch)
         nxt_prdata[PORT_W-1:0] = latch_ff;
      else if (sel_ansel)
         nxt_prdata[PORT_W-1:0] = ansel_ff;
   end

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   // pready rises in the second access cycle and drops right after.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end
      else
      begin
         pready_ff  <= access_start;
         pslverr_ff <= access_start & ~mapped;
         if (access_start && !pwrite)
            prdata_ff <= nxt_prdata;
      end
   end

   assign prdata       = prdata_ff;
   assign pready       = pready_ff;
   assign pslverr      = pslverr_ff;
   assign analog_ctl   = analog_ff;
   assign irq_request  = irq_ff;
   assign wake_request = wake_ff;

endmodule : dual_comparator_control

// [sim/dual_comparator_control_props.sv]
// Purpose: Concurrent checks on the comparator control ports.
// Assumes: One clock domain, pclk, with presetn active low.
// Notes:   Bound into the design; it watches bus, cmp1_raw and sleep inputs as well as driven outputs.
`timescale 1ns/1ps
module dual_comparator_control_props #(
   parameter int unsigned PORT_W = 8
) (
   input wire logic                          pclk,
   input wire logic                          presetn,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire logic [cmp_ctl_pkg::ADDR_W-1:0] paddr,
   input wire logic [cmp_ctl_pkg::DATA_W-1:0] pwdata,
   input wire logic [cmp_ctl_pkg::DATA_W-1:0] prdata,
   input wire logic                          pready,
   input wire logic                          pslverr,
   input wire logic                          cmp1_raw,
   input wire logic                          sleep_mode,
   input wire logic [PORT_W-1:0]             pin_out,
   input wire logic [PORT_W-1:0]             pin_oe_n,
   input wire cmp_ctl_pkg::analog_ctl_t      analog_ctl,
   input wire logic                          wake_request
);
   import cmp_ctl_pkg::*;
   // ----------------------------------------------------------------
   // Helper strobes
   // ----------------------------------------------------------------
   // Named strobes keep the properties short and readable.
   wire done    = psel && penable && pready;
   wire first   = psel && penable && !pready;
   wire wr_done = done && pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_ready_wait: assert property (first |=> pready)
      else $error("pready missing after the wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_pair: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_decode: assert property (done |->
      pslverr == (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0))
      else $error("pslverr wrong for this address");
   a_rdata_upper: assert property (done && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_mode_write: assert property (wr_done && paddr == OFF_CTRL |->
      ##2 analog_ctl.mode == $past(pwdata[2:0], 2))
      else $error("mode field not applied");
   a_ref_mode: assert property (
      analog_ctl.ref_on_positive == (analog_ctl.mode == MODE_MUX4))
      else $error("internal reference outside four-input mode");
   a_neg_ref: assert property (
      analog_ctl.neg_to_ref_pins |-> analog_ctl.mode == MODE_MUX4)
      else $error("input switch acting outside four-input mode");
   a_dir_write: assert property (wr_done && paddr == OFF_DIR |=>
      pin_oe_n == $past(pwdata[PORT_W-1:0]))
      else $error("direction write not on output enables");
   a_pin_follow: assert property (analog_ctl.mode == MODE_PIN_OUT &&
      $stable(analog_ctl) && $changed(cmp1_raw) && !$past(wr_done)
      |-> $changed(pin_out[PIN_CMP1]))
      else $error("pin does not follow raw comparator level");
   a_wake_sleep: assert property (wake_request |-> $past(sleep_mode))
      else $error("wake request outside sleep");
   a_reset_state: assert property ($rose(presetn) |->
      analog_ctl.mode == MODE_OFF && pin_oe_n == '1)
      else $error("state after reset wrong");
endmodule : dual_comparator_control_props

bind dual_comparator_control dual_comparator_control_props #(
   .PORT_W(PORT_W)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cmp1_raw(cmp1_raw), .sleep_mode(sleep_mode), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n), .analog_ctl(analog_ctl),
   .wake_request(wake_request));

// [sim/dual_comparator_control_test.sv]
// Purpose: Self-checking bench for the comparator control block.
// Assumes: APB answers after one wait state; raw levels need 3 edges.
// Notes:   Register table first, then change flag, pins, modes, reset.
`timescale 1ns/1ps
module dual_comparator_control_test;
   import cmp_ctl_pkg::*;
   typedef struct packed
   {
      logic [7:0]  a;
      logic [31:0] rst, wv, rb;
      logic        err;
   } row_t;
   logic        pclk, pready, pslverr, irq_request, wake_request, err;
   logic        presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        cmp1_raw = 1'h0, cmp2_raw = 1'h0, sleep_mode = 1'h0;
   logic [7:0]  paddr = 8'h00, pin_in = 8'hFF, pin_out, pin_oe_n;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   analog_ctl_t analog_ctl;
   int          fails = 0, tests_run = 0, cycles = 0;
   // Address, reset value, write value, read-back, refused.
   row_t rows [9] = '{
      '{8'h00, 32'h07, 32'hC7, 32'h07, 1'h0},
      '{8'h04, 32'h0, 32'h40, 32'h40, 1'h0},
      '{8'h08, 32'h0, 32'h40, 32'h40, 1'h0},
      '{8'h0C, 32'h0, 32'hC0, 32'hC0, 1'h0},
      '{8'h10, 32'hFF, 32'hCF, 32'hCF, 1'h0},
      '{8'h14, 32'hF0, 32'h0, 32'hF0, 1'h0},
      '{8'h18, 32'h0, 32'h5A, 32'h5A, 1'h0},
      '{8'h1C, 32'h0F, 32'h03, 32'h03, 1'h0},
      '{8'h20, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h1}};
   dual_comparator_control #(.PORT_W(8)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw),
      .sleep_mode(sleep_mode), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .analog_ctl(analog_ctl),
      .irq_request(irq_request), .wake_request(wake_request));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task summarize();
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Request is held from setup until pready is seen at an edge.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask : rd_chk
   task tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tick
   // ----------------------------------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------------------------------
   // Free-running 250 MHz clock.
   initial
   begin
      pclk = 1'h0;
      forever #2 pclk = ~pclk;
   end
   // A hang counts as a mismatch and ends the run.
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         summarize();
      end
   end
   // Register table, then the hand-written cases.
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      foreach (rows[i])
      begin
         rd_chk(rows[i].a, rows[i].rst);
         apb(1'h1, rows[i].a, rows[i].wv);
         chk({31'h0, err}, {31'h0, rows[i].err});
         rd_chk(rows[i].a, rows[i].rb);
      end
      tick(2);
      chk({24'h0, pin_oe_n}, 32'hCF);
      chk({24'h0, pin_out}, 32'h5A);
      chk({31'h0, irq_request}, 32'h1);
      apb(1'h1, OFF_INTCTL, 32'h40);
      tick(2);
      chk({31'h0, irq_request}, 32'h0);
      rd_chk(OFF_FLAG, 32'h40);
      apb(1'h1, OFF_ENABLE, 32'h0);
      apb(1'h1, OFF_CTRL, 32'h0);
      apb(1'h1, OFF_FLAG, 32'h0);
      rd_chk(OFF_FLAG, 32'h0);
      apb(1'h1, OFF_ENABLE, 32'h40);
      apb(1'h1, OFF_INTCTL, 32'hC0);
      @(posedge pclk);
      cmp1_raw <= 1'h1;
      tick(5);
      chk({31'h0, irq_request}, 32'h1);
      apb(1'h1, OFF_FLAG, 32'h0);
      rd_chk(OFF_FLAG, 32'h40);
      rd_chk(OFF_CTRL, 32'h40);
      apb(1'h1, OFF_FLAG, 32'h0);
      rd_chk(OFF_FLAG, 32'h0);
      apb(1'h1, OFF_CTRL, 32'h10);
      tick(4);
      rd_chk(OFF_CTRL, 32'h10);
      @(posedge pclk);
      cmp2_raw <= 1'h1;
      tick(5);
      rd_chk(OFF_CTRL, 32'h90);
      apb(1'h1, OFF_CTRL, 32'h30);
      tick(4);
      rd_chk(OFF_CTRL, 32'h30);
      // Pin mode passes the raw levels straight through.
      apb(1'h1, OFF_CTRL, {29'h0, MODE_PIN_OUT});
      for (int i = 0; i < 4; i++)
      begin
         @(posedge pclk);
         {cmp2_raw, cmp1_raw} <= i[1:0];
         #1;
         chk({30'h0, pin_out[5:4]}, {30'h0, i[1:0]});
      end
      chk({24'h0, pin_oe_n}, 32'hCF);
      for (int m = 0; m < 8; m++)
      begin
         apb(1'h1, OFF_CTRL, 32'h8 | m);
         tick(2);
         chk({25'h0, analog_ctl}, {25'h0, m != 7, m != 7, m == 6, m == 6,
            m[2:0]});
      end
      apb(1'h1, OFF_CTRL, 32'h06);
      tick(2);
      chk({31'h0, analog_ctl.neg_to_ref_pins}, 32'h0);
      @(posedge pclk);
      sleep_mode <= 1'h1;
      apb(1'h1, OFF_FLAG, 32'h40);
      tick(2);
      chk({31'h0, wake_request}, 32'h1);
      rd_chk(OFF_CTRL, 32'hC6);
      @(posedge pclk);
      sleep_mode <= 1'h0;
      presetn <= 1'h0;
      tick(1);
      chk({24'h0, pin_oe_n}, 32'hFF);
      chk({29'h0, analog_ctl.mode}, 32'h7);
      @(posedge pclk);
      presetn <= 1'h1;
      rd_chk(OFF_CTRL, 32'h07);
      summarize();
   end
endmodule : dual_comparator_control_test
